//--- hw/cmpd_defines.vh
// constants for the comparator event and debounce block
`ifndef CMPD_DEFINES_VH
`define CMPD_DEFINES_VH

// register indices as printed and as chosen, byte address is four times
`define CMPD_IDX_CTRL        12'h097
`define CMPD_IDX_INT_EN      12'h0A8
`define CMPD_IDX_IRQ_STAT    12'h0A9
`define CMPD_IDX_IRQ_MASK    12'h0AA
`define CMPD_ADDR_W          12

// control/status field positions
`define CMPD_SEL_LSB         0
`define CMPD_SEL_MSB         2
`define CMPD_BIT_ON          3
`define CMPD_BIT_FLAG        4
`define CMPD_BIT_IDLE_RUN    5
`define CMPD_BIT_INT_EN_CMP  6

// reset values
`define CMPD_RST_CTRL        8'h00
`define CMPD_RST_INT_EN      8'h00
`define CMPD_RST_SEL         3'h0
`define CMPD_RST_IRQ         2'h0

// event select codes
`define CMPD_SEL_LOW         3'h0
`define CMPD_SEL_RISE        3'h1
`define CMPD_SEL_DB_TOG      3'h2
`define CMPD_SEL_DB_RISE     3'h3
`define CMPD_SEL_FALL        3'h4
`define CMPD_SEL_TOG         3'h5
`define CMPD_SEL_DB_FALL     3'h6
`define CMPD_SEL_HIGH        3'h7

// timer overflows to wait before the debounce resample
`define CMPD_DB_OVF_COUNT    2'h2

// interrupt status bit positions
`define CMPD_IRQ_MATCH       0
`define CMPD_IRQ_REJECT      1

// bus responses
`define CMPD_RESP_OKAY       2'h0
`define CMPD_RESP_DECERR     2'h3

`endif

//--- hw/cmpd_sync2.v
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module cmpd_sync2 (
    // clock and reset
    input  wire core_clk_i,
    input  wire resetn_i,
    // asynchronous level in, synchronised level out
    input  wire async_i,
    output wire sync_o
);
    reg meta_r;  // first stage, read only by the second
    reg sync_r;  // second stage

    // two stage capture
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule // cmpd_sync2

//--- hw/cmpd_top.v
// comparator event detection, debounce, control register and bus slave
//
// Summary of operation
// [R1] output high only when positive exceeds negative
// [R2] sample comparator output every clock, check condition
// [R3] three debounced modes timed by timer overflows
// [R4] debounce resamples after two timer overflows
// [R5] matching resample sets flag, mismatch discards
// [R6] ignore transitions while debounce wait runs
// [R7] event_select bits 2:0 pick the mode
// [R8] flag bit 4 set by hardware, software clears
// [R9] request raised only while enable bit 6 set
// [R10] comparator_on clear forces output low, blocks events
// [R11] run_in_idle keeps comparator working in idle
// [R12] idle event with interrupt enabled wakes processor
// [R13] power-down always disables comparator and events
// [R14] control register resets to zero, top bits undefined
`timescale 1ns/1ps
`include "cmpd_defines.vh"
module cmpd_top (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        resetn_i,
    // analog comparator and system status
    input  wire        cmp_raw_i,
    input  wire        t1_ovf_i,
    input  wire        idle_i,
    input  wire        power_down_i,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    // axi4-lite write response
    output wire [1:0]  s_axi_bresp_o,
    output wire        s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0]  s_axi_rresp_o,
    output wire        s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    // results
    output wire        comp_out_o,
    output wire        cmp_req_o,
    output wire        wake_o,
    output wire        irq_o
);
    localparam ST_SCAN = 1'b0;  // looking for a qualifying transition
    localparam ST_WAIT = 1'b1;  // debounce wait in progress

    // register index from a byte address, 3'h4 means unmapped
    function [2:0] reg_sel;
        input [11:0] addr;
        begin
            if (addr[1:0] != 2'h0)
                reg_sel = 3'h4;
            else if (addr[11:2] == `CMPD_IDX_CTRL)
                reg_sel = 3'h0;
            else if (addr[11:2] == `CMPD_IDX_INT_EN)
                reg_sel = 3'h1;
            else if (addr[11:2] == `CMPD_IDX_IRQ_STAT)
                reg_sel = 3'h2;
            else if (addr[11:2] == `CMPD_IDX_IRQ_MASK)
                reg_sel = 3'h3;
            else
                reg_sel = 3'h4;
        end
    endfunction

    // software state
    reg  [2:0]  sel_r;        // event_select
    reg         on_r;         // comparator_on
    reg         flag_r;       // match_event_flag
    reg         idle_run_r;   // run_in_idle
    reg         int_en_r;     // comparator bit of interrupt enable
    reg  [1:0]  irq_stat_r;   // sticky status
    reg  [1:0]  irq_mask_r;   // status mask
    // bus state
    reg         awready_r;    // write address slot free
    reg         wready_r;     // write data slot free
    reg         aw_hold_r;    // address captured
    reg         w_hold_r;     // data captured
    reg  [11:0] aw_addr_r;    // captured write address
    reg  [7:0]  w_data_r;     // captured low byte
    reg         w_be0_r;      // low byte strobe
    reg         bvalid_r;     // write response pending
    reg  [1:0]  bresp_r;      // write response code
    reg         arready_r;    // read address slot free
    reg         rvalid_r;     // read data pending
    reg  [31:0] rdata_r;      // read data
    reg  [1:0]  rresp_r;      // read response code
    // event state
    reg         comp_r;       // gated comparator output
    reg         prev_r;       // previous gated sample
    reg         st_r;         // debounce state
    reg         expect_r;     // level expected after the transition
    reg  [1:0]  ovf_cnt_r;    // timer overflows seen
    reg         req_r;        // interrupt request
    reg         wake_r;       // wake from idle
    reg         irq_r;        // masked interrupt
    // next values
    reg         st_nxt;
    reg         expect_nxt;
    reg  [1:0]  ovf_cnt_nxt;
    reg         set_evt;      // flag set this cycle
    reg         rej_evt;      // debounce discard this cycle
    reg  [31:0] rd_mux;       // read data selection

    wire        cmp_sync;     // synchronised analog result
    wire        active;       // comparator powered and enabled
    wire        rise;         // rising transition
    wire        fall;         // falling transition
    wire        wr_go;        // both halves of a write present
    wire [2:0]  wr_sel;       // write target
    wire [2:0]  rd_sel;       // read target
    wire        ar_take;      // read address handshake

    // analog result arrives asynchronously
    cmpd_sync2 u_sync (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    (cmp_raw_i),
        .sync_o     (cmp_sync)
    );

    // enabled, not powered down, and awake or allowed in idle
    assign active = on_r & ~power_down_i &       // [R10] [R13]
                    (~idle_i | idle_run_r);      // [R11]
    assign rise   = comp_r & ~prev_r;
    assign fall   = ~comp_r & prev_r;
    assign wr_go  = aw_hold_r & w_hold_r & ~bvalid_r;
    assign wr_sel = reg_sel(aw_addr_r);
    assign rd_sel = reg_sel(s_axi_araddr_i);
    assign ar_take = s_axi_arvalid_i & arready_r;

    // sample comparator each clock, forced low when inactive
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            comp_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            comp_r <= active & cmp_sync;  // [R1] [R2] [R10]
            prev_r <= comp_r;
        end
    end

    // event detection and debounce sequencing
    always @* begin
        st_nxt      = st_r;
        expect_nxt  = expect_r;
        ovf_cnt_nxt = ovf_cnt_r;
        set_evt     = 1'b0;
        rej_evt     = 1'b0;
        if (!active) begin
            st_nxt      = ST_SCAN;  // [R10] [R13]
            ovf_cnt_nxt = 2'h0;
        end else begin
            case (st_r)
                ST_SCAN: begin
                    case (sel_r)  // [R7]
                        `CMPD_SEL_LOW:  set_evt = ~comp_r;
                        `CMPD_SEL_HIGH: set_evt = comp_r;
                        `CMPD_SEL_RISE: set_evt = rise;
                        `CMPD_SEL_FALL: set_evt = fall;
                        `CMPD_SEL_TOG:  set_evt = rise | fall;
                        `CMPD_SEL_DB_TOG: begin  // [R3]
                            if (rise | fall) begin
                                st_nxt     = ST_WAIT;
                                expect_nxt = comp_r;
                            end
                        end
                        `CMPD_SEL_DB_RISE: begin  // [R3]
                            if (rise) begin
                                st_nxt     = ST_WAIT;
                                expect_nxt = 1'b1;
                            end
                        end
                        `CMPD_SEL_DB_FALL: begin  // [R3]
                            if (fall) begin
                                st_nxt     = ST_WAIT;
                                expect_nxt = 1'b0;
                            end
                        end
                        default: set_evt = 1'b0;
                    endcase
                    ovf_cnt_nxt = 2'h0;
                end
                ST_WAIT: begin
                    // transitions during the wait are not looked at
                    if (ovf_cnt_r == `CMPD_DB_OVF_COUNT) begin  // [R4] [R6]
                        st_nxt      = ST_SCAN;
                        ovf_cnt_nxt = 2'h0;
                        set_evt     = (comp_r == expect_r);   // [R5]
                        rej_evt     = (comp_r != expect_r);   // [R5]
                    end else if (t1_ovf_i) begin
                        ovf_cnt_nxt = ovf_cnt_r + 2'h1;       // [R4]
                    end
                end
                default: st_nxt = ST_SCAN;
            endcase
        end
    end

    // debounce state registers
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r      <= ST_SCAN;
            expect_r  <= 1'b0;
            ovf_cnt_r <= 2'h0;
        end else begin
            st_r      <= st_nxt;
            expect_r  <= expect_nxt;
            ovf_cnt_r <= ovf_cnt_nxt;
        end
    end

    // control, enable and interrupt registers; hardware set beats clear
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_r      <= `CMPD_RST_SEL;                   // [R14]
            on_r       <= 1'b0;                            // [R14]
            flag_r     <= 1'b0;                            // [R14]
            idle_run_r <= 1'b0;                            // [R14]
            int_en_r   <= 1'b0;
            irq_stat_r <= `CMPD_RST_IRQ;
            irq_mask_r <= `CMPD_RST_IRQ;
        end else begin
            if (wr_go && w_be0_r && wr_sel == 3'h0) begin
                sel_r      <= w_data_r[`CMPD_SEL_MSB:`CMPD_SEL_LSB];
                on_r       <= w_data_r[`CMPD_BIT_ON];
                idle_run_r <= w_data_r[`CMPD_BIT_IDLE_RUN];
                flag_r     <= w_data_r[`CMPD_BIT_FLAG] | set_evt; // [R8]
            end else if (set_evt) begin
                flag_r <= 1'b1;  // [R8]
            end
            if (wr_go && w_be0_r && wr_sel == 3'h1)
                int_en_r <= w_data_r[`CMPD_BIT_INT_EN_CMP];
            if (wr_go && w_be0_r && wr_sel == 3'h2)
                irq_stat_r <= (irq_stat_r & ~w_data_r[1:0]) |
                              {rej_evt, set_evt};
            else
                irq_stat_r <= irq_stat_r | {rej_evt, set_evt};
            if (wr_go && w_be0_r && wr_sel == 3'h3)
                irq_mask_r <= w_data_r[1:0];
        end
    end

    // request, wake and interrupt outputs
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_r  <= 1'b0;
            wake_r <= 1'b0;
            irq_r  <= 1'b0;
        end else begin
            req_r  <= flag_r & int_en_r;                         // [R9]
            wake_r <= idle_i & idle_run_r & int_en_r &           // [R12]
                      (flag_r | set_evt);
            irq_r  <= |(irq_stat_r & irq_mask_r);
        end
    end

    // read data selection, upper bits read as zero
    always @* begin
        rd_mux = 32'h0000_0000;
        case (rd_sel)
            3'h0: rd_mux[7:0] = {2'h0, idle_run_r, flag_r, on_r, sel_r};
            3'h1: rd_mux[`CMPD_BIT_INT_EN_CMP] = int_en_r;
            3'h2: rd_mux[1:0] = irq_stat_r;
            3'h3: rd_mux[1:0] = irq_mask_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // write channel: take address and data in any order, then answer
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r  <= 8'h00;
            w_be0_r   <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `CMPD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && awready_r) begin
                aw_addr_r <= s_axi_awaddr_i;
                aw_hold_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid_i && wready_r) begin
                w_data_r <= s_axi_wdata_i[7:0];
                w_be0_r  <= s_axi_wstrb_i[0];
                w_hold_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= (wr_sel == 3'h4) ? `CMPD_RESP_DECERR
                                              : `CMPD_RESP_OKAY;
            end
            if (bvalid_r && s_axi_bready_i) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // read channel: answer one cycle after the address is taken
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `CMPD_RESP_OKAY;
        end else begin
            if (ar_take) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_mux;
                rresp_r   <= (rd_sel == 3'h4) ? `CMPD_RESP_DECERR
                                              : `CMPD_RESP_OKAY;
            end else if (rvalid_r && s_axi_rready_i) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // outputs straight from flops
    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o  = wready_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign comp_out_o      = comp_r;
    assign cmp_req_o       = req_r;
    assign wake_o          = wake_r;
    assign irq_o           = irq_r;
endmodule // cmpd_top

//--- sim/cmpd_partner.sv
// model of the analog comparator and the free running overflow timer
`timescale 1ns/1ps
module cmpd_partner #(
    parameter int OVF_PERIOD = 8  // cycles between timer overflows
) (
    // clock and reset
    input  logic       core_clk_i,
    input  logic       resetn_i,
    // analog levels, comparator result and timer pulse
    input  logic [7:0] pos_lvl_i,
    input  logic [7:0] neg_lvl_i,
    output logic       cmp_raw_o,
    output logic       t1_ovf_o
);
    logic [7:0] tick_r;  // timer count
    // high only when the positive input is above the negative
    assign cmp_raw_o = pos_lvl_i > neg_lvl_i;
    // free running timer, one pulse per period, never stops
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_r   <= 8'h00;
            t1_ovf_o <= 1'b0;
        end else begin
            t1_ovf_o <= (tick_r == 8'(OVF_PERIOD - 1));
            tick_r   <= (tick_r == 8'(OVF_PERIOD - 1)) ? 8'h00
                                                       : tick_r + 8'h01;
        end
    end
endmodule // cmpd_partner

//--- sim/cmpd_top_asserts.sv
// concurrent checks on the ports of the comparator event block
`timescale 1ns/1ps
module cmpd_top_asserts (
    // clock, reset and system inputs
    input logic        core_clk_i,
    input logic        resetn_i,
    input logic        cmp_raw_i,
    input logic        idle_i,
    input logic        power_down_i,
    // register bus
    input logic        s_axi_awvalid_i,
    input logic        s_axi_awready_o,
    input logic        s_axi_wvalid_i,
    input logic        s_axi_wready_o,
    input logic        s_axi_bvalid_o,
    input logic        s_axi_bready_i,
    input logic [1:0]  s_axi_bresp_o,
    input logic        s_axi_arvalid_i,
    input logic        s_axi_arready_o,
    input logic        s_axi_rvalid_o,
    input logic        s_axi_rready_i,
    input logic [31:0] s_axi_rdata_o,
    // results
    input logic        comp_out_o,
    input logic        cmp_req_o,
    input logic        wake_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // address and data of a write taken at one edge
    sequence wr_both_s;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    // read address taken
    sequence rd_take_s;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    // power-down held long enough to pass the pipeline
    sequence pd_held_s;
        power_down_i [*3];
    endsequence
    // both halves held at one edge, response raised two edges later
    write_answer_a: assert property (wr_both_s |-> ##2 s_axi_bvalid_o)
        else $error("write response late");
    read_answer_a: assert property (rd_take_s |=> s_axi_rvalid_o)
        else $error("read response late");
    bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    bus_busy_a: assert property ((s_axi_bvalid_o |-> !s_axi_awready_o
        && !s_axi_wready_o) and (s_axi_rvalid_o |-> !s_axi_arready_o))
        else $error("request accepted while busy");
    pd_gate_a: assert property (pd_held_s |=> !comp_out_o)
        else $error("output high in power-down");
    comp_cause_a: assert property ($rose(comp_out_o)
        |-> $past(cmp_raw_i, 3) || $past(cmp_raw_i, 4))
        else $error("output rose without input");
    flag_sticky_a: assert property (cmp_req_o && !s_axi_bvalid_o
        |=> cmp_req_o)
        else $error("request fell without a write");
    wake_cause_a: assert property (wake_o |-> $past(idle_i))
        else $error("wake outside idle");
endmodule // cmpd_top_asserts
bind cmpd_top cmpd_top_asserts i_cmpd_top_asserts (.*);

//--- sim/cmpd_top_test.sv
// self-checking bench of the comparator event block
`timescale 1ns/1ps
`include "cmpd_defines.vh"
module cmpd_top_test;
    localparam logic [11:0] A_CTRL = `CMPD_IDX_CTRL << 2;
    localparam logic [11:0] A_INT  = `CMPD_IDX_INT_EN << 2;
    localparam logic [11:0] A_STAT = `CMPD_IDX_IRQ_STAT << 2;
    localparam logic [11:0] A_MASK = `CMPD_IDX_IRQ_MASK << 2;
    localparam logic [7:0]  ON     = 8'h08;  // comparator_on
    localparam logic [7:0]  A_HIGH = 8'h71;  // modes starting high
    logic        core_clk_i = 1'b0, resetn_i = 1'b0;
    logic        idle_i = 1'b0, power_down_i = 1'b0;
    logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic        s_axi_rready_i = 1'b0;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    wire         s_axi_arready_o, s_axi_rvalid_o, cmp_raw_i, t1_ovf_i;
    wire         comp_out_o, cmp_req_o, wake_o, irq_o;
    wire [1:0]   s_axi_bresp_o, s_axi_rresp_o;
    wire [31:0]  s_axi_rdata_o;
    logic [7:0]  pos_lvl = 8'h40;  // above or below the fixed 0x60
    int          num_errors = 0, num_checks = 0, cyc = 0;
    logic [31:0] d;
    logic [1:0]  r;
    always #2 core_clk_i = ~core_clk_i;
    cmpd_partner i_cmpd_partner (.core_clk_i(core_clk_i),
        .resetn_i(resetn_i), .pos_lvl_i(pos_lvl), .neg_lvl_i(8'h60),
        .cmp_raw_o(cmp_raw_i), .t1_ovf_o(t1_ovf_i));
    cmpd_top i_cmpd_top (.*);
    task tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // move the analog input above or below the reference
    task lvl(input logic b);
        @(posedge core_clk_i);
        pos_lvl <= b ? 8'h80 : 8'h40;
    endtask
    // one bus write, response compared with the expected code
    task wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] e);
        @(posedge core_clk_i);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= {24'h000000, v};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        s_axi_bready_i <= 1'b0;
        chk(s_axi_bresp_o === e, "write response");
    endtask
    // one bus read
    task rd(input logic [11:0] a);
        @(posedge core_clk_i);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask
    task bit_is(input logic [11:0] a, input int b, input logic e);
        rd(a);
        chk(d[b] === e && r === `CMPD_RESP_OKAY, "register bit");
    endtask
    // reset values and an unmapped place
    task t_reset;
        rd(A_CTRL);
        chk(d === 32'h0000_0000, "control reset");
        rd(A_INT);
        chk(d === 32'h0000_0000, "enable reset");
        wr(12'h004, 8'hFF, `CMPD_RESP_DECERR);
        rd(12'h004);
        chk(r === `CMPD_RESP_DECERR, "unmapped read");
    endtask
    // every event mode: clear, then the qualifying change sets the flag
    task t_modes;
        logic a;
        for (int i = 0; i < 8; i++) begin
            a = A_HIGH[i];
            lvl(a);
            wr(A_CTRL, 8'(i), `CMPD_RESP_OKAY);
            wr(A_CTRL, ON | 8'(i), `CMPD_RESP_OKAY);
            tick(40);
            wr(A_CTRL, ON | 8'(i), `CMPD_RESP_OKAY);
            bit_is(A_CTRL, 4, 1'b0);
            lvl(!a);
            tick(40);
            bit_is(A_CTRL, 4, 1'b1);
        end
    endtask
    // short pulse in debounced toggle mode: later fall ignored, then rejected
    task t_reject;
        lvl(1'b0);
        wr(A_CTRL, ON | 8'h02, `CMPD_RESP_OKAY);
        // the fall from the last mode is debounced too; let it finish
        tick(30);
        wr(A_CTRL, ON | 8'h02, `CMPD_RESP_OKAY);
        wr(A_STAT, 8'h03, `CMPD_RESP_OKAY);
        lvl(1'b1);
        tick(1);
        lvl(1'b0);
        tick(40);
        bit_is(A_CTRL, 4, 1'b0);
        bit_is(A_STAT, 1, 1'b1);
        bit_is(A_STAT, 0, 1'b0);
    endtask
    // off and power-down gating, then interrupt enable masking
    task t_gate;
        lvl(1'b1);
        wr(A_CTRL, 8'h07, `CMPD_RESP_OKAY);
        tick(20);
        chk(comp_out_o === 1'b0, "output while off");
        bit_is(A_CTRL, 4, 1'b0);
        power_down_i <= 1'b1;
        wr(A_CTRL, ON | 8'h07, `CMPD_RESP_OKAY);
        tick(20);
        chk(comp_out_o === 1'b0, "output in power-down");
        bit_is(A_CTRL, 4, 1'b0);
        power_down_i <= 1'b0;
        tick(20);
        chk(comp_out_o === 1'b1, "output follows input");
        bit_is(A_CTRL, 4, 1'b1);
        wr(A_INT, 8'h40, `CMPD_RESP_OKAY);
        tick(2);
        chk(cmp_req_o === 1'b1, "request enabled");
        wr(A_INT, 8'h00, `CMPD_RESP_OKAY);
        tick(2);
        chk(cmp_req_o === 1'b0, "request masked");
    endtask
    // idle with and without run_in_idle
    task t_idle;
        wr(A_CTRL, 8'h20 | ON | 8'h07, `CMPD_RESP_OKAY);
        wr(A_INT, 8'h40, `CMPD_RESP_OKAY);
        idle_i <= 1'b1;
        tick(10);
        chk(wake_o === 1'b1, "wake from idle");
        chk(comp_out_o === 1'b1, "runs in idle");
        wr(A_CTRL, ON | 8'h07, `CMPD_RESP_OKAY);
        tick(20);
        chk(comp_out_o === 1'b0, "off in idle");
        // the set won as run_in_idle dropped; clear it while asleep
        wr(A_CTRL, ON | 8'h07, `CMPD_RESP_OKAY);
        tick(10);
        bit_is(A_CTRL, 4, 1'b0);
        chk(wake_o === 1'b0, "wake without run_in_idle");
        idle_i <= 1'b0;
        wr(A_INT, 8'h00, `CMPD_RESP_OKAY);
    endtask
    // status raised, masked and cleared
    task t_irq;
        lvl(1'b0);
        wr(A_CTRL, ON | 8'h01, `CMPD_RESP_OKAY);
        wr(A_STAT, 8'h03, `CMPD_RESP_OKAY);
        wr(A_MASK, 8'h01, `CMPD_RESP_OKAY);
        tick(2);
        chk(irq_o === 1'b0, "interrupt idle");
        lvl(1'b1);
        tick(10);
        chk(irq_o === 1'b1, "interrupt raised");
        wr(A_MASK, 8'h00, `CMPD_RESP_OKAY);
        tick(2);
        chk(irq_o === 1'b0, "interrupt masked");
        wr(A_MASK, 8'h01, `CMPD_RESP_OKAY);
        wr(A_STAT, 8'h01, `CMPD_RESP_OKAY);
        tick(2);
        chk(irq_o === 1'b0, "interrupt cleared");
    endtask
    // cut a hang short
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish;
        end
    end
    initial begin
        tick(8);
        resetn_i <= 1'b1;
        t_reset;
        t_modes;
        t_reject;
        t_gate;
        t_idle;
        t_irq;
        tally_and_finish;
    end
endmodule // cmpd_top_test
